/* hw/lsr_pkg.sv */
// package: offsets, reset values, channel codes and thresholds of the limit status registers
package lsr_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] INT_TEMP_OFFSET = 8'h1f;
  localparam logic [7:0] STATUS_ONE_OFFSET = 8'h20;
  localparam logic [7:0] ANALOG_STATUS_OFFSET = 8'h21;

  // ---------------------------------------------------------------
  // reset values and widths
  // ---------------------------------------------------------------
  localparam int REG_WIDTH = 8;
  localparam logic [7:0] INT_TEMP_RESET = 8'h00;
  localparam logic [7:0] STATUS_ONE_RESET = 8'h00;
  localparam logic [7:0] ANALOG_STATUS_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ---------------------------------------------------------------
  // status one bit positions
  // ---------------------------------------------------------------
  localparam int REMOTE_ONE_BIT = 0;
  localparam int REMOTE_TWO_BIT = 1;
  localparam int STANDBY_BIT = 2;
  localparam int MAIN_BIT = 3;
  localparam int FIVE_BIT = 4;
  localparam int CORE_BIT = 5;
  localparam int STATUS_ONE_USED = 6;
  localparam int ANALOG_COUNT = 8;

  // ---------------------------------------------------------------
  // thermal-limit mode hysteresis, one degree per lsb
  // ---------------------------------------------------------------
  localparam int THERMAL_HYSTERESIS_DEGC = 5;
  localparam logic [7:0] THERMAL_HYSTERESIS = 8'(THERMAL_HYSTERESIS_DEGC);

  // ---------------------------------------------------------------
  // channel codes of the conversion sequencer
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    CH_REMOTE_ONE,
    CH_REMOTE_TWO,
    CH_STANDBY,
    CH_MAIN,
    CH_FIVE,
    CH_CORE,
    CH_ANALOG_ZERO,
    CH_ANALOG_ONE,
    CH_ANALOG_TWO,
    CH_ANALOG_THREE,
    CH_ANALOG_FOUR,
    CH_ANALOG_FIVE,
    CH_ANALOG_SIX,
    CH_ANALOG_SEVEN,
    CH_ANALOG_NINE,
    CH_INTERNAL
  } lsr_channel_t;

endpackage : lsr_pkg

/* hw/lsr_window_check.sv */
// window comparator: flags a value above its high or below its low limit
module lsr_window_check #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] value,
  input wire logic [WIDTH-1:0] highLimit,
  input wire logic [WIDTH-1:0] lowLimit,
  output logic outside
);

  assign outside = (value > highLimit) || (value < lowLimit);

endmodule : lsr_window_check

/* hw/lsr_thermal_track.sv */
// thermal-limit mode tracker for one temperature channel, with engage and disengage pulses
module lsr_thermal_track (
  input wire logic clock,
  input wire logic reset,
  input wire logic update,
  input wire logic [7:0] reading,
  input wire logic [7:0] limit,
  output logic engage,
  output logic disengage,
  output logic modeActive
);

  logic mode_q;
  logic belowRelease;

  // compare in nine bits so a limit under the hysteresis never releases by wrap
  assign belowRelease = ({1'b0, reading} + {1'b0, lsr_pkg::THERMAL_HYSTERESIS})
    <= {1'b0, limit};
  assign engage = update && !mode_q && (reading > limit);
  assign disengage = update && mode_q && belowRelease;
  assign modeActive = mode_q;

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      mode_q <= 1'b0;
    end
    else if (engage)
    begin
      mode_q <= 1'b1;
    end
    else if (disengage)
    begin
      mode_q <= 1'b0;
    end
  end

endmodule : lsr_thermal_track

/* hw/lsr_limit_status.sv */
// limit status registers: window and thermal-limit status bits, internal temperature byte
//
// Notes on behaviour
// - The internal temperature byte holds the latest internal reading, read-only, zero at reset.
// - The first status register sits at 20h, eight bits, read-only, zero at reset.
// - Remote one's status bit is 1 when its last conversion was above high or below low limit.
// - Remote one's bit is also set once when thermal-limit mode engages on that channel.
// - Remote one's bit is set once more when that channel falls 5 degrees below its limit.
// - Remote two's bit flags its window result, or analog input nine's in voltage mode.
// - Remote two's bit is set once on thermal-limit engage and once on disengage.
// - The standby rail bit is 1 when its last conversion was outside its limits.
// - The main 3.3 V rail bit is 1 when its last conversion was outside its limits.
// - The 5 V rail bit is 1 when its last conversion was outside its limits.
// - The analog status byte holds one window bit per analog input zero to seven.
module lsr_limit_status (
  input wire logic clock,
  input wire logic reset,
  input wire logic resultValid,
  input wire lsr_pkg::lsr_channel_t resultChannel,
  input wire logic [7:0] resultValue,
  input wire logic [7:0] highLimit,
  input wire logic [7:0] lowLimit,
  input wire logic [7:0] thermalLimitOne,
  input wire logic [7:0] thermalLimitTwo,
  input wire logic remoteTwoVoltageMode,
  input wire logic [7:0] readAddr,
  output logic [7:0] readData,
  output logic thermalLimitMode
);

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  // ---------------------------------------------------------------
  // result qualification
  // ---------------------------------------------------------------
  logic outside;
  logic [lsr_pkg::STATUS_ONE_USED-1:0] statusStrobe;
  logic [lsr_pkg::STATUS_ONE_USED-1:0] thermalEvent;
  logic [lsr_pkg::ANALOG_COUNT-1:0] analogStrobe;
  logic remoteOneEngage;
  logic remoteOneDisengage;
  logic remoteOneMode;
  logic remoteTwoEngage;
  logic remoteTwoDisengage;
  logic remoteTwoMode;
  logic remoteTwoTempUpdate;
  logic internalStrobe;
  logic [7:0] intTemp_q;
  logic [7:0] statusOne_q;
  logic [7:0] analogStatus_q;
  logic [7:0] readData_q;
  logic [7:0] readData_d;
  logic thermalMode_q;

  lsr_window_check #(
    .WIDTH(lsr_pkg::REG_WIDTH)
  ) windowCheck (
    .value(resultValue),
    .highLimit(highLimit),
    .lowLimit(lowLimit),
    .outside(outside)
  );

  // remote two source select
  // in voltage mode the bit follows analog input nine and the temperature path idles
  assign remoteTwoTempUpdate = resultValid && !remoteTwoVoltageMode
    && (resultChannel == lsr_pkg::CH_REMOTE_TWO);

  always_comb
  begin
    statusStrobe = '0;
    statusStrobe[lsr_pkg::REMOTE_ONE_BIT] = resultValid
      && (resultChannel == lsr_pkg::CH_REMOTE_ONE);
    statusStrobe[lsr_pkg::REMOTE_TWO_BIT] = resultValid && (remoteTwoVoltageMode
      ? (resultChannel == lsr_pkg::CH_ANALOG_NINE) : (resultChannel == lsr_pkg::CH_REMOTE_TWO));
    statusStrobe[lsr_pkg::STANDBY_BIT] = resultValid && (resultChannel == lsr_pkg::CH_STANDBY);
    statusStrobe[lsr_pkg::MAIN_BIT] = resultValid && (resultChannel == lsr_pkg::CH_MAIN);
    statusStrobe[lsr_pkg::FIVE_BIT] = resultValid && (resultChannel == lsr_pkg::CH_FIVE);
    statusStrobe[lsr_pkg::CORE_BIT] = resultValid && (resultChannel == lsr_pkg::CH_CORE);
  end

  assign internalStrobe = resultValid && (resultChannel == lsr_pkg::CH_INTERNAL);

  // ---------------------------------------------------------------
  // thermal-limit mode tracking
  // ---------------------------------------------------------------
  lsr_thermal_track remoteOneTrack (
    .clock(clock),
    .reset(reset),
    .update(statusStrobe[lsr_pkg::REMOTE_ONE_BIT]),
    .reading(resultValue),
    .limit(thermalLimitOne),
    .engage(remoteOneEngage),
    .disengage(remoteOneDisengage),
    .modeActive(remoteOneMode)
  );

  lsr_thermal_track remoteTwoTrack (
    .clock(clock),
    .reset(reset),
    .update(remoteTwoTempUpdate),
    .reading(resultValue),
    .limit(thermalLimitTwo),
    .engage(remoteTwoEngage),
    .disengage(remoteTwoDisengage),
    .modeActive(remoteTwoMode)
  );

  always_comb
  begin
    thermalEvent = '0;
    thermalEvent[lsr_pkg::REMOTE_ONE_BIT] = remoteOneEngage || remoteOneDisengage;
    thermalEvent[lsr_pkg::REMOTE_TWO_BIT] = remoteTwoEngage || remoteTwoDisengage;
  end

  // registered so the mode output comes straight from a flop, one cycle behind the trackers
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      thermalMode_q <= 1'b0;
    end
    else
    begin
      thermalMode_q <= remoteOneMode || remoteTwoMode;
    end
  end

  assign thermalLimitMode = thermalMode_q;

  // ---------------------------------------------------------------
  // status register one
  // ---------------------------------------------------------------
  // per-channel re-evaluation
  // a bit only moves at its own conversion end, so a read between conversions is stable
  for (genvar i = 0; i < lsr_pkg::STATUS_ONE_USED; i++)
  begin : gStatusOne
    always_ff @(posedge clock or posedge reset)
    begin
      if (reset)
      begin
        statusOne_q[i] <= lsr_pkg::STATUS_ONE_RESET[i];
      end
      else if (statusStrobe[i])
      begin
        statusOne_q[i] <= outside || thermalEvent[i];
      end
    end
  end

  // upper bits are not assigned to any channel and read as zero
  assign statusOne_q[7:lsr_pkg::STATUS_ONE_USED] = '0;

  // ---------------------------------------------------------------
  // analog input status register
  // ---------------------------------------------------------------
  // analog window bits
  for (genvar i = 0; i < lsr_pkg::ANALOG_COUNT; i++)
  begin : gAnalog
    assign analogStrobe[i] = resultValid
      && (resultChannel == lsr_pkg::lsr_channel_t'(5'(lsr_pkg::CH_ANALOG_ZERO) + 5'(i)));

    always_ff @(posedge clock or posedge reset)
    begin
      if (reset)
      begin
        analogStatus_q[i] <= lsr_pkg::ANALOG_STATUS_RESET[i];
      end
      else if (analogStrobe[i])
      begin
        analogStatus_q[i] <= outside;
      end
    end

    a_analog_window: assert property (analogStrobe[i]
      |=> analogStatus_q[i] == $past(outside))
      else $error("analog status bit missed its window result");
  end

  // ---------------------------------------------------------------
  // internal temperature byte
  // ---------------------------------------------------------------
  // internal reading capture
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      intTemp_q <= lsr_pkg::INT_TEMP_RESET;
    end
    else if (internalStrobe)
    begin
      intTemp_q <= resultValue;
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  // register decode
  always_comb
  begin
    unique case (readAddr)
      lsr_pkg::INT_TEMP_OFFSET: readData_d = intTemp_q;
      lsr_pkg::STATUS_ONE_OFFSET: readData_d = statusOne_q;
      lsr_pkg::ANALOG_STATUS_OFFSET: readData_d = analogStatus_q;
      default: readData_d = lsr_pkg::UNMAPPED_READ;
    endcase
  end

  // reads have no side effect, so the data is simply sampled every cycle
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      readData_q <= lsr_pkg::UNMAPPED_READ;
    end
    else
    begin
      readData_q <= readData_d;
    end
  end

  assign readData = readData_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_temp_capture: assert property (internalStrobe |=> intTemp_q == $past(resultValue))
    else $error("internal temperature byte not captured");

  a_status_read: assert property (readAddr == lsr_pkg::STATUS_ONE_OFFSET
    && !(|statusStrobe) |=> readData == statusOne_q)
    else $error("status one not visible at its offset");

  a_unmapped_read: assert property (readAddr != lsr_pkg::INT_TEMP_OFFSET
    && readAddr != lsr_pkg::STATUS_ONE_OFFSET && readAddr != lsr_pkg::ANALOG_STATUS_OFFSET
    |=> readData == lsr_pkg::UNMAPPED_READ)
    else $error("unmapped address did not read zero");

  a_remote_one_window: assert property (statusStrobe[lsr_pkg::REMOTE_ONE_BIT]
    && !thermalEvent[lsr_pkg::REMOTE_ONE_BIT]
    |=> statusOne_q[lsr_pkg::REMOTE_ONE_BIT] == $past(outside))
    else $error("remote one bit does not follow its window");

  a_remote_one_engage: assert property (remoteOneEngage
    |=> statusOne_q[lsr_pkg::REMOTE_ONE_BIT] && remoteOneMode)
    else $error("remote one engage not flagged");

  a_mode_output: assert property (remoteOneEngage || remoteTwoEngage
    |=> ##1 thermalLimitMode)
    else $error("thermal-limit mode output not raised");

  a_remote_one_release: assert property (remoteOneDisengage
    |-> resultValue <= thermalLimitOne - lsr_pkg::THERMAL_HYSTERESIS
    ##1 statusOne_q[lsr_pkg::REMOTE_ONE_BIT] && !remoteOneMode)
    else $error("remote one release not flagged");

  a_remote_two_voltage: assert property (resultValid && remoteTwoVoltageMode
    && resultChannel == lsr_pkg::CH_ANALOG_NINE
    |=> statusOne_q[lsr_pkg::REMOTE_TWO_BIT] == $past(outside))
    else $error("remote two bit ignores analog input nine");

  a_remote_two_window: assert property (statusStrobe[lsr_pkg::REMOTE_TWO_BIT]
    && !remoteTwoVoltageMode && !thermalEvent[lsr_pkg::REMOTE_TWO_BIT]
    |=> statusOne_q[lsr_pkg::REMOTE_TWO_BIT] == $past(outside))
    else $error("remote two bit does not follow its window");

  a_remote_two_event: assert property (remoteTwoEngage || remoteTwoDisengage
    |=> statusOne_q[lsr_pkg::REMOTE_TWO_BIT])
    else $error("remote two thermal event not flagged");

  a_standby_window: assert property (statusStrobe[lsr_pkg::STANDBY_BIT]
    |=> statusOne_q[lsr_pkg::STANDBY_BIT] == $past(outside))
    else $error("standby rail bit wrong");

  a_main_window: assert property (statusStrobe[lsr_pkg::MAIN_BIT]
    |=> statusOne_q[lsr_pkg::MAIN_BIT] == $past(outside))
    else $error("main rail bit wrong");

  a_five_window: assert property (statusStrobe[lsr_pkg::FIVE_BIT]
    |=> statusOne_q[lsr_pkg::FIVE_BIT] == $past(outside))
    else $error("five volt rail bit wrong");

  a_core_window: assert property (statusStrobe[lsr_pkg::CORE_BIT]
    |=> statusOne_q[lsr_pkg::CORE_BIT] == $past(outside))
    else $error("core rail bit wrong");

  a_event_single: assert property (remoteOneEngage |=> !remoteOneEngage [*2])
    else $error("engage event repeated");

  a_bit_holds: assert property (!statusStrobe[lsr_pkg::STANDBY_BIT]
    |=> $stable(statusOne_q[lsr_pkg::STANDBY_BIT]))
    else $error("status bit moved without a conversion");

  c_engage: cover property (remoteOneEngage ##[1:50] remoteOneDisengage);
  c_voltage_mode: cover property (statusStrobe[lsr_pkg::REMOTE_TWO_BIT] && remoteTwoVoltageMode
    && outside);
  c_analog_hit: cover property (analogStrobe[lsr_pkg::ANALOG_COUNT-1] && outside);
  c_status_read: cover property (readAddr == lsr_pkg::STATUS_ONE_OFFSET ##1 readData != 8'h00);

endmodule : lsr_limit_status

/* testbench/lsr_host_model.sv */
// host-side model: presents conversion results and reads back register bytes
module lsr_host_model (
  input wire logic clock,
  output logic resultValid,
  output lsr_pkg::lsr_channel_t resultChannel,
  output logic [7:0] resultValue,
  output logic [7:0] highLimit,
  output logic [7:0] lowLimit,
  output logic [7:0] readAddr,
  input wire logic [7:0] readData
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    resultValid = 1'b0;
    resultChannel = lsr_pkg::CH_INTERNAL;
    resultValue = 8'h00;
    highLimit = 8'h00;
    lowLimit = 8'h00;
    readAddr = 8'h00;
  end

  task send(input lsr_pkg::lsr_channel_t ch, input logic [7:0] v, input logic [7:0] h,
    input logic [7:0] l);
    @(posedge clock);
    resultValid <= 1'b1;
    resultChannel <= ch;
    resultValue <= v;
    highLimit <= h;
    lowLimit <= l;
    @(posedge clock);
    resultValid <= 1'b0;
    // idle fields scrambled so a stale value never looks like a result
    resultChannel <= lsr_pkg::lsr_channel_t'(~ch);
    resultValue <= ~v;
    highLimit <= ~h;
    lowLimit <= ~l;
  endtask : send

  task read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    readAddr <= a;
    @(posedge clock);
    #1 d = readData;
  endtask : read
endmodule : lsr_host_model

/* testbench/lsr_limit_status_bench.sv */
// self-checking bench of the limit status registers
`define CHK(what, expv, gotv) \
  begin \
    checks++; \
    if ((gotv) !== (expv)) \
    begin \
      mismatches++; \
      $display("wrong value %s expected %h seen %h", what, expv, gotv); \
    end \
  end

module lsr_limit_status_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic resultValid;
  lsr_pkg::lsr_channel_t resultChannel;
  logic [7:0] resultValue;
  logic [7:0] highLimit;
  logic [7:0] lowLimit;
  logic [7:0] readAddr;
  logic [7:0] readData;
  logic [7:0] thermalLimitOne = 8'hff;
  logic [7:0] thermalLimitTwo = 8'hff;
  logic remoteTwoVoltageMode = 1'b0;
  logic thermalLimitMode;
  int mismatches = 0;
  int checks = 0;
  int seed = 61;
  logic [7:0] expOne = 8'h00;
  logic [7:0] expAna = 8'h00;
  logic [7:0] expTemp = 8'h00;
  logic [7:0] got;
  lsr_pkg::lsr_channel_t ch;
  logic [7:0] v;
  logic [7:0] h;
  logic [7:0] l;
  int idx;

  always #20 clock = ~clock;

  lsr_host_model HOST (.clock(clock), .resultValid(resultValid),
    .resultChannel(resultChannel), .resultValue(resultValue), .highLimit(highLimit),
    .lowLimit(lowLimit), .readAddr(readAddr), .readData(readData));

  lsr_limit_status DUT (.clock(clock), .reset(reset), .resultValid(resultValid),
    .resultChannel(resultChannel), .resultValue(resultValue), .highLimit(highLimit),
    .lowLimit(lowLimit), .thermalLimitOne(thermalLimitOne),
    .thermalLimitTwo(thermalLimitTwo), .remoteTwoVoltageMode(remoteTwoVoltageMode),
    .readAddr(readAddr), .readData(readData), .thermalLimitMode(thermalLimitMode));

  function automatic logic outside(input logic [7:0] a, input logic [7:0] hi,
    input logic [7:0] lo);
    return (a > hi) || (a < lo);
  endfunction : outside

  function automatic void predict(input lsr_pkg::lsr_channel_t c, input logic [7:0] a,
    input logic [7:0] hi, input logic [7:0] lo);
    if (c == lsr_pkg::CH_INTERNAL)
      expTemp = a;
    else if (c == lsr_pkg::CH_ANALOG_NINE || c == lsr_pkg::CH_REMOTE_TWO)
    begin
      // the shared bit follows whichever source the voltage mode selects
      if ((c == lsr_pkg::CH_ANALOG_NINE) == remoteTwoVoltageMode)
        expOne[lsr_pkg::REMOTE_TWO_BIT] = outside(a, hi, lo);
    end
    else if (c <= lsr_pkg::CH_CORE)
      expOne[int'(c)] = outside(a, hi, lo);
    else
      expAna[int'(c) - int'(lsr_pkg::CH_ANALOG_ZERO)] = outside(a, hi, lo);
  endfunction : predict

  task put(input lsr_pkg::lsr_channel_t c, input logic [7:0] a, input logic [7:0] hi,
    input logic [7:0] lo);
    HOST.send(c, a, hi, lo);
    predict(c, a, hi, lo);
  endtask : put

  task check_regs;
    HOST.read(lsr_pkg::INT_TEMP_OFFSET, got);
    `CHK("temperature byte", expTemp, got);
    HOST.read(lsr_pkg::STATUS_ONE_OFFSET, got);
    `CHK("status one", expOne, got);
    HOST.read(lsr_pkg::ANALOG_STATUS_OFFSET, got);
    `CHK("analog status", expAna, got);
  endtask : check_regs

  task finish_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  // ---------------------------------------------------------------
  // watchdog
  // ---------------------------------------------------------------
  initial
  begin
    #1000000;
    mismatches++;
    finish_test();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    check_regs();
    HOST.read(8'h22, got);
    `CHK("unmapped byte", lsr_pkg::UNMAPPED_READ, got);
    $display("test reset done");
    // limit boundaries are inside the window
    for (int i = 0; i < 4; i++)
    begin
      v = (i == 0) ? 8'h80 : (i == 1) ? 8'h81 : (i == 2) ? 8'h10 : 8'h0f;
      put(lsr_pkg::CH_FIVE, v, 8'h80, 8'h10);
      put(lsr_pkg::CH_ANALOG_SEVEN, v, 8'h80, 8'h10);
      check_regs();
    end
    $display("test boundaries done");
    // random results, at least one idle cycle apart, in any order
    for (int i = 0; i < 150; i++)
    begin
      idx = $unsigned($random(seed)) % 15;
      ch = (idx == 14) ? lsr_pkg::CH_INTERNAL : lsr_pkg::lsr_channel_t'(idx);
      v = $random(seed);
      h = $random(seed);
      l = $random(seed);
      put(ch, v, h, l);
      if (i % 5 == 4)
        check_regs();
    end
    $display("test random done");
    // voltage mode reports analog input nine
    @(posedge clock);
    remoteTwoVoltageMode <= 1'b1;
    put(lsr_pkg::CH_ANALOG_NINE, 8'h90, 8'h80, 8'h10);
    check_regs();
    // in voltage mode a remote two temperature result must leave the bit alone
    put(lsr_pkg::CH_REMOTE_TWO, 8'h50, 8'h80, 8'h10);
    check_regs();
    put(lsr_pkg::CH_ANALOG_NINE, 8'h50, 8'h80, 8'h10);
    check_regs();
    @(posedge clock);
    remoteTwoVoltageMode <= 1'b0;
    thermalLimitOne <= 8'h50;
    thermalLimitTwo <= 8'h50;
    $display("test voltage mode done");
    // engage above limit, release five below, one flag each
    for (int c = 0; c < 2; c++)
    begin
      for (int i = 0; i < 5; i++)
      begin
        v = (i < 2) ? 8'h51 : (i == 2) ? 8'h4c : 8'h4b;
        put(lsr_pkg::lsr_channel_t'(c), v, 8'hff, 8'h00);
        expOne[c] = (i == 0) || (i == 3);
        check_regs();
        `CHK("thermal mode", (i < 3) ? 1'b1 : 1'b0, thermalLimitMode);
      end
    end
    $display("test thermal mode done");
    finish_test();
  end
endmodule : lsr_limit_status_bench
